// file: rec_clk_pkg.sv
// constants for the record-path clock configuration block
package rec_clk_pkg;

   // ==========================================
   // register indices (byte address = 4 * index)
   localparam logic [7:0] IDX_PROC_DIV  = 8'h12;
   localparam logic [7:0] IDX_MOD_DIV   = 8'h13;
   localparam logic [7:0] IDX_OSR       = 8'h14;
   localparam logic [7:0] IDX_INSTR     = 8'h15;
   localparam logic [7:0] IDX_DECIM     = 8'h16;
   localparam logic [7:0] IDX_STATUS    = 8'h20;
   localparam int         IDX_LSB       = 2;

   // ==========================================
   // reset values
   localparam logic [7:0] RST_PROC_DIV  = 8'h01;
   localparam logic [7:0] RST_MOD_DIV   = 8'h01;
   localparam logic [7:0] RST_OSR       = 8'h80;
   localparam logic [7:0] RST_INSTR     = 8'h80;
   localparam logic [7:0] RST_DECIM     = 8'h04;

   // ==========================================
   // field layout
   localparam int         EN_BIT        = 7;
   localparam int         DIV_W         = 7;
   localparam int         OSR_W         = 8;
   localparam int         DEC_W         = 4;
   localparam int         CNT_W         = 9;
   localparam int         NUM_DIV       = 3;
   localparam logic [7:0] INSTR_MAX     = 8'hc0;
   localparam logic [3:0] DEC_RSV_ZERO  = 4'h0;

   // ==========================================
   // status bit positions
   localparam int         ST_PROC_RUN   = 0;
   localparam int         ST_MOD_RUN    = 1;
   localparam int         ST_INSTR_BAD  = 2;
   localparam int         ST_OSR_ODD    = 3;
   localparam int         ST_BUDGET_ODD = 4;

endpackage

// file: rec_clk_cfg.sv
// record-path clock dividers and engine settings behind an apb slave
//
// Overview of operation
// - processing divider enable low bypasses to the playback processing clock.
// - processing divider code divides by its value; zero divides by 128.
// - modulator divider enable low bypasses to the playback modulator clock.
// - modulator divider code divides by its value; zero divides by 128.
// - oversampling code divides by its value; zero divides by 256.
// - instruction budget is twice the code, codes 1 to 192.
// - decimation code gives its value; zero gives 16.
// - decimation upper nibble is reserved and resets to zero.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module rec_clk_cfg
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // source clock ticks, same domain
   input  wire logic        codec_clkin_tick,
   input  wire logic        playback_processing_tick,
   input  wire logic        playback_modulator_clock,
   // record clock ticks
   output logic             record_processing_tick,
   output logic             record_modulator_clock,
   output logic             record_sample_tick,
   // engine settings
   output logic [8:0]       instr_budget,
   output logic [4:0]       decim_ratio
);
   import rec_clk_pkg::*;

   // ==========================================
   // ratio decode

   // code zero selects the full power of two
   function automatic logic [CNT_W-1:0] ratio_of(input logic [7:0] code,
                                                 input int        w);
      logic [CNT_W-1:0] r;
      r = CNT_W'(code);
      if (w < 8)
         r = CNT_W'(code & 8'((1 << w) - 1));
      if (r == '0)
         r = CNT_W'(1 << w);
      return r;
   endfunction

   // ==========================================
   // registers
   logic [7:0] proc_div_reg;
   logic [7:0] mod_div_reg;
   logic [7:0] osr_reg;
   logic [7:0] instr_reg;
   logic [7:0] decim_reg;

   // apb decode; paddr bits above the index are ignored, so the map
   // repeats and software must not rely on aliases
   wire logic [7:0] idx     = paddr[IDX_LSB+7:IDX_LSB];
   wire logic       hit_pd  = (idx == IDX_PROC_DIV);
   wire logic       hit_md  = (idx == IDX_MOD_DIV);
   wire logic       hit_os  = (idx == IDX_OSR);
   wire logic       hit_in  = (idx == IDX_INSTR);
   wire logic       hit_dc  = (idx == IDX_DECIM);
   wire logic       hit_st  = (idx == IDX_STATUS);
   wire logic       mapped  = hit_pd | hit_md | hit_os | hit_in | hit_dc
                              | hit_st;
   wire logic       access  = psel & penable;
   wire logic       wr_ok   = access & pwrite & mapped & pstrb[0];

   // zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // byte-wide registers take lane 0 only
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         proc_div_reg <= RST_PROC_DIV;
         mod_div_reg  <= RST_MOD_DIV;
         osr_reg      <= RST_OSR;
         instr_reg    <= RST_INSTR;
         decim_reg    <= RST_DECIM;
      end
      else if (wr_ok)
      begin
         if (hit_pd) proc_div_reg <= pwdata[7:0];
         if (hit_md) mod_div_reg  <= pwdata[7:0];
         if (hit_os) osr_reg      <= pwdata[7:0];
         if (hit_in) instr_reg    <= pwdata[7:0];
         if (hit_dc) decim_reg    <= pwdata[7:0];
      end
   end

   // ==========================================
   // engine settings

   wire logic [8:0] budget_next = {instr_reg, 1'b0};
   wire logic [4:0] decim_next  = 5'(ratio_of(8'(decim_reg[DEC_W-1:0]), DEC_W));

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         instr_budget <= '0;
         decim_ratio  <= '0;
      end
      else
      begin
         instr_budget <= budget_next;
         decim_ratio  <= decim_next;
      end
   end

   // ==========================================
   // divider chain: processing, modulator, oversampling
   logic [NUM_DIV-1:0] src;
   logic [NUM_DIV-1:0] en;
   logic [NUM_DIV-1:0] byp;
   logic [NUM_DIV-1:0] out_reg;
   logic [CNT_W-1:0]   ratio [NUM_DIV];
   logic [CNT_W-1:0]   cnt_reg [NUM_DIV];

   // limitation: a source held high counts on every cycle, so sources
   // must be one-cycle pulses for the ratios to mean anything
   // the first stage counts codec_clkin_tick; each later stage counts the ticks of the stage before
   assign src[0] = codec_clkin_tick;
   assign src[1] = out_reg[0];
   assign src[2] = out_reg[1];

   assign en[0]  = proc_div_reg[EN_BIT];
   assign byp[0] = playback_processing_tick;
   assign en[1]  = mod_div_reg[EN_BIT];
   assign byp[1] = playback_modulator_clock;
   // oversampling divider has no power-down
   assign en[2]  = 1'b1;
   assign byp[2] = 1'b0;

   assign ratio[0] = ratio_of(proc_div_reg, DIV_W);
   assign ratio[1] = ratio_of(mod_div_reg, DIV_W);
   assign ratio[2] = ratio_of(osr_reg, OSR_W);

   // counter wraps on >= so a smaller ratio written mid-count recovers
   // at once; a powered-down stage holds its counter at zero
   for (genvar i = 0; i < NUM_DIV; i++)
   begin : g_div
      wire logic wrap = src[i] & (cnt_reg[i] >= ratio[i] - CNT_W'(1));
      wire logic [CNT_W-1:0] cnt_next =
         !en[i] ? '0 : wrap ? '0 : src[i] ? cnt_reg[i] + CNT_W'(1)
                                          : cnt_reg[i];
      wire logic out_next = en[i] ? wrap : byp[i];

      always_ff @(posedge mclk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            cnt_reg[i] <= '0;
            out_reg[i] <= 1'b0;
         end
         else
         begin
            cnt_reg[i] <= cnt_next;
            out_reg[i] <= out_next;
         end
      end
   end

   assign record_processing_tick = out_reg[0];
   assign record_modulator_clock = out_reg[1];
   assign record_sample_tick     = out_reg[2];

   // ==========================================
   // status and read data

   // flags help software catch the programming it is asked to avoid
   wire logic instr_bad = (instr_reg == 8'h00) | (instr_reg > INSTR_MAX);
   wire logic osr_odd   = (ratio[2] % CNT_W'(decim_next)) != '0;
   wire logic bud_odd   = (budget_next % 9'(decim_next)) != '0;
   wire logic [7:0] status;
   assign status[ST_PROC_RUN]       = en[0];
   assign status[ST_MOD_RUN]        = en[1];
   assign status[ST_INSTR_BAD]      = instr_bad;
   assign status[ST_OSR_ODD]        = osr_odd;
   assign status[ST_BUDGET_ODD]     = bud_odd;
   assign status[7:ST_BUDGET_ODD+1] = '0;

   wire logic [7:0] rd_byte =
      hit_pd ? proc_div_reg :
      hit_md ? mod_div_reg  :
      hit_os ? osr_reg      :
      hit_in ? instr_reg    :
      hit_dc ? decim_reg    :
      hit_st ? status       : 8'h00;

   // live decode of the addressed byte; only meaningful in the access phase
   assign prdata = {24'h000000, rd_byte};

   // ==========================================
   // checks
   // guards on $past(rst_b) skip the first edge after release, where the
   // registered outputs still show their reset values
   sequence proc_wrap_s;
      en[0] && src[0] && cnt_reg[0] == ratio[0] - CNT_W'(1);
   endsequence

   sequence mod_wrap_s;
      en[1] && src[1] && cnt_reg[1] == ratio[1] - CNT_W'(1);
   endsequence

   proc_bypass_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $past(rst_b) && !en[0] |=> record_processing_tick == $past(playback_processing_tick))
      else $error("processing bypass wrong");

   proc_ratio_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      proc_wrap_s |=> record_processing_tick && cnt_reg[0] == '0)
      else $error("processing divider missed its wrap");

   mod_bypass_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $past(rst_b) && !en[1] |=> record_modulator_clock == $past(playback_modulator_clock))
      else $error("modulator bypass wrong");

   mod_ratio_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      mod_wrap_s |=> record_modulator_clock && cnt_reg[1] == '0)
      else $error("modulator divider missed its wrap");

   osr_ratio_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      record_sample_tick |-> $past(cnt_reg[2]) >= $past(ratio[2]) - 9'd1)
      else $error("sample tick before oversampling count");

   budget_twice_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $past(rst_b) |-> instr_budget == 9'({$past(instr_reg), 1'b0}))
      else $error("instruction budget not twice the code");

   decim_value_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $past(rst_b) |-> decim_ratio == (($past(decim_reg[3:0]) == 4'h0) ? 5'd16
                                       : 5'($past(decim_reg[3:0]))))
      else $error("decimation ratio decode wrong");

   decim_rsv_a: assert property (
      @(posedge mclk)
      $rose(rst_b) |-> decim_reg[7:4] == DEC_RSV_ZERO)
      else $error("decimation reserved bits not cleared");

   chain_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      en[1] && $past(en[1]) && !$past(record_processing_tick)
      |-> cnt_reg[1] == $past(cnt_reg[1]))
      else $error("modulator counted without processing tick");

   // powered-down stages hold their counters at zero
   proc_off_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !en[0] |=> cnt_reg[0] == '0)
      else $error("powered-down processing divider kept counting");

   mod_off_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !en[1] |=> cnt_reg[1] == '0)
      else $error("powered-down modulator divider kept counting");

   // a counted tick always leaves the counter below the ratio in force
   proc_range_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      en[0] && src[0] |=> cnt_reg[0] < $past(ratio[0]))
      else $error("processing count passed its ratio");

   mod_range_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      en[1] && src[1] |=> cnt_reg[1] < $past(ratio[1]))
      else $error("modulator count passed its ratio");

   osr_range_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      src[2] |=> cnt_reg[2] < $past(ratio[2]))
      else $error("oversampling count passed its ratio");

   osr_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $past(rst_b) && !$past(record_modulator_clock)
      |-> cnt_reg[2] == $past(cnt_reg[2]))
      else $error("oversampling counted without modulator tick");

   // ==========================================
   // register bus checks
   sequence osr_write_s;
      access && pwrite && pstrb[0] && idx == IDX_OSR;
   endsequence

   // writes that must leave every register alone
   sequence ignored_write_s;
      access && pwrite && (!pstrb[0] || !mapped || hit_st);
   endsequence

   osr_write_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      osr_write_s |=> osr_reg == $past(pwdata[7:0]))
      else $error("oversampling write did not land");

   write_ignored_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      ignored_write_s |=> $stable(proc_div_reg) && $stable(mod_div_reg)
                          && $stable(osr_reg) && $stable(instr_reg) && $stable(decim_reg))
      else $error("ignored write changed a register");

   refused_read_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      access && !mapped |-> pslverr && prdata == '0)
      else $error("unmapped access not refused");

   // a mapped access never reports an error
   mapped_ok_a: assert property (
      @(posedge mclk) disable iff (!rst_b)
      access && mapped |-> !pslverr)
      else $error("mapped access reported an error");

endmodule

// file: adc_clock_divider_config_tb.sv
// self-checking testbench for the record-path clock configuration block
`timescale 1ns/1ps

module adc_clock_divider_config_tb;
   import rec_clk_pkg::*;

   // ==========================================
   // stimulus and observed signals
   logic        mclk                     = 1'b0;
   logic        rst_b                    = 1'b0;
   logic        psel                     = 1'b0;
   logic        penable                  = 1'b0;
   logic        pwrite                   = 1'b0;
   logic [11:0] paddr                    = 12'h000;
   logic [31:0] pwdata                   = 32'h0;
   logic [3:0]  pstrb                    = 4'hf;
   logic        codec_clkin_tick         = 1'b1;
   logic        playback_processing_tick = 1'b0;
   logic        playback_modulator_clock = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        record_processing_tick;
   logic        record_modulator_clock;
   logic        record_sample_tick;
   logic [8:0]  instr_budget;
   logic [4:0]  decim_ratio;
   logic [31:0] rd;
   logic        er;
   int          errors                   = 0;
   int          compares                 = 0;
   int          cyc                      = 0;
   wire  [2:0]  tk = {record_sample_tick, record_modulator_clock, record_processing_tick};

   // 200 MHz clock
   always #2.5 mclk = ~mclk;

   // playback sources: processing every 2nd cycle, modulator every 5th
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      playback_processing_tick <= cyc[0];
      playback_modulator_clock <= (cyc % 5 == 0);
   end

   rec_clk_cfg dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .codec_clkin_tick(codec_clkin_tick),
      .playback_processing_tick(playback_processing_tick),
      .playback_modulator_clock(playback_modulator_clock),
      .record_processing_tick(record_processing_tick),
      .record_modulator_clock(record_modulator_clock),
      .record_sample_tick(record_sample_tick), .instr_budget(instr_budget),
      .decim_ratio(decim_ratio));

   // ==========================================
   // report and compare
   task summarize();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer; waits an edge first so psel is never set twice at once
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n >= 16)
      begin
         errors++;
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(name, exp, rd);
   endtask

   // cycles between pulses; early intervals skipped as counters settle
   task gap(input int k, output int g);
      int n;
      for (int p = 0; p < 4; p++)
      begin
         n = 0;
         @(posedge mclk);
         while (tk[k] !== 1'b1 && n < 3000)
         begin
            @(posedge mclk);
            n++;
         end
         if (n >= 3000)
         begin
            errors++;
            summarize();
         end
         g = n + 1;
      end
   endtask

   // ==========================================
   // scenarios
   task t_reset();
      rdchk("proc_div", IDX_PROC_DIV, 32'h01);
      rdchk("mod_div", IDX_MOD_DIV, 32'h01);
      rdchk("osr", IDX_OSR, 32'h80);
      rdchk("instr", IDX_INSTR, 32'h80);
      rdchk("decim", IDX_DECIM, 32'h04);
      chk("mapped err", 32'h0, {31'h0, er});
      chk("budget", 32'h100, {23'h0, instr_budget});
      chk("ratio", 32'h4, {27'h0, decim_ratio});
      apb(1'b1, 8'h30, 8'h5a);
      chk("unmapped err", 32'h1, {31'h0, er});
      rdchk("unmapped", 8'h30, 32'h0);
   endtask

   // each step keeps oversampling and budget multiples of the decimation
   task t_fields();
      apb(1'b1, IDX_DECIM, 8'h00);
      repeat (2) @(posedge mclk);
      chk("ratio zero", 32'h10, {27'h0, decim_ratio});
      apb(1'b1, IDX_DECIM, 8'h01);
      apb(1'b1, IDX_INSTR, 8'h01);
      repeat (2) @(posedge mclk);
      chk("ratio one", 32'h01, {27'h0, decim_ratio});
      chk("budget min", 32'h2, {23'h0, instr_budget});
      apb(1'b1, IDX_INSTR, 8'h0f);
      apb(1'b1, IDX_OSR, 8'hf0);
      apb(1'b1, IDX_DECIM, 8'h0f);
      repeat (2) @(posedge mclk);
      chk("ratio max", 32'h0f, {27'h0, decim_ratio});
      chk("budget 30", 32'h1e, {23'h0, instr_budget});
      rdchk("status clean", IDX_STATUS, 32'h00);
      apb(1'b1, IDX_DECIM, 8'h01);
      apb(1'b1, IDX_INSTR, 8'hc0);
      apb(1'b1, IDX_OSR, 8'h80);
      apb(1'b1, IDX_DECIM, 8'h04);
      repeat (2) @(posedge mclk);
      chk("budget max", 32'h180, {23'h0, instr_budget});
      // a write without lane 0 strobe leaves the register alone
      pstrb <= 4'h0;
      apb(1'b1, IDX_OSR, 8'h55);
      pstrb <= 4'hf;
      rdchk("osr kept", IDX_OSR, 32'h80);
   endtask

   task t_div(input logic [7:0] p, input logic [7:0] m, input logic [7:0] o,
              input int k, input int exp);
      int g;
      apb(1'b1, IDX_PROC_DIV, p);
      apb(1'b1, IDX_MOD_DIV, m);
      apb(1'b1, IDX_OSR, o);
      rdchk("status", IDX_STATUS, {30'h0, m[7], p[7]});
      gap(k, g);
      chk("tick gap", exp, g);
   endtask

   initial
   begin
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_fields();
      t_div(8'h01, 8'h01, 8'h80, 0, 2);
      t_div(8'h01, 8'h01, 8'h80, 1, 5);
      t_div(8'h83, 8'h01, 8'h80, 0, 3);
      t_div(8'h80, 8'h01, 8'h80, 0, 128);
      t_div(8'h83, 8'h82, 8'h80, 1, 6);
      t_div(8'h81, 8'h80, 8'h80, 1, 128);
      t_div(8'h81, 8'h81, 8'h00, 2, 256);
      t_div(8'h01, 8'h01, 8'h04, 2, 20);
      summarize();
   end
endmodule
